// >>> vr_regmap_pkg.sv
package vr_regmap_pkg;

    // ****************************************
    // entry indices
    // ****************************************
    localparam logic [7:0] IDX_MAKER_CODE       = 8'h00;
    localparam logic [7:0] IDX_PART_CODE        = 8'h01;
    localparam logic [7:0] IDX_PART_REVISION    = 8'h02;
    localparam logic [7:0] IDX_MANUFACTURE_DATE = 8'h03;
    localparam logic [7:0] IDX_MANUFACTURE_LOT  = 8'h04;
    localparam logic [7:0] IDX_PROTOCOL_VERSION = 8'h05;
    localparam logic [7:0] IDX_FEATURE_FLAGS    = 8'h06;
    localparam logic [7:0] IDX_FAULT_PRIMARY    = 8'h10;
    localparam logic [7:0] IDX_FAULT_SECONDARY  = 8'h11;
    localparam logic [7:0] IDX_THERMAL_ZONE     = 8'h12;
    localparam logic [7:0] IDX_OUT_CURRENT      = 8'h15;
    localparam logic [7:0] IDX_OUT_VOLTAGE      = 8'h16;
    localparam logic [7:0] IDX_REG_TEMPERATURE  = 8'h17;
    localparam logic [7:0] IDX_OUT_POWER        = 8'h18;
    localparam logic [7:0] IDX_IN_CURRENT       = 8'h19;
    localparam logic [7:0] IDX_IN_VOLTAGE       = 8'h1a;
    localparam logic [7:0] IDX_IN_POWER         = 8'h1b;
    localparam logic [7:0] IDX_SECONDARY_SNAP   = 8'h1c;
    localparam logic [7:0] IDX_MAX_CURRENT      = 8'h21;
    localparam logic [7:0] IDX_MAX_TEMPERATURE  = 8'h22;
    localparam logic [7:0] IDX_FAST_SLEW        = 8'h24;
    localparam logic [7:0] IDX_SLOW_SLEW        = 8'h25;
    localparam logic [7:0] IDX_STARTUP_VOLTAGE  = 8'h26;
    localparam logic [7:0] IDX_SCRATCH_FIRST    = 8'h30;
    localparam logic [7:0] IDX_SCRATCH_LAST     = 8'h35;
    localparam logic [7:0] IDX_VOUT_CEILING     = 8'h30;
    localparam logic [7:0] IDX_VOLTAGE_TARGET   = 8'h31;
    localparam logic [7:0] IDX_POWER_STATE      = 8'h32;
    localparam logic [7:0] IDX_VOLTAGE_OFFSET   = 8'h33;
    localparam logic [7:0] IDX_MULTI_REG_CONFIG = 8'h34;
    localparam logic [7:0] IDX_POINTER_COPY     = 8'h35;

    // ****************************************
    // fixed and default values
    // ****************************************
    localparam logic [7:0] RST_PROTOCOL_VERSION = 8'h02;
    localparam logic [7:0] RST_FEATURE_FLAGS    = 8'hd7;
    localparam logic [7:0] RST_STATUS           = 8'h00;
    localparam logic [7:0] RST_MAX_CURRENT      = 8'h00;
    localparam logic [7:0] RST_MAX_TEMPERATURE  = 8'h96;
    localparam logic [7:0] RST_STARTUP_VOLTAGE  = 8'h7e;
    localparam logic [7:0] RST_VOUT_CEILING     = 8'hff;
    localparam logic [7:0] RST_SCRATCH          = 8'h00;
    localparam logic [7:0] SLEW_FAST_10         = 8'h0a;
    localparam logic [7:0] SLEW_FAST_20         = 8'h14;
    localparam logic [7:0] SLEW_SLOW_FOR_10     = 8'h02;
    localparam logic [7:0] SLEW_SLOW_FOR_20     = 8'h05;
    localparam logic [7:0] READ_UNMAPPED        = 8'h00;
    localparam int         SCRATCH_COUNT        = 6;

    // ****************************************
    // bus command codes
    // ****************************************
    typedef enum logic [2:0] {
        CMD_SET_VOLTAGE_FAST = 3'h1,
        CMD_SET_VOLTAGE_SLOW = 3'h2,
        CMD_SET_VOLTAGE_DECAY = 3'h3,
        CMD_SET_POWER_STATE  = 3'h4,
        CMD_REGISTER_POINTER = 3'h5,
        CMD_REGISTER_WRITE   = 3'h6,
        CMD_REGISTER_READ    = 3'h7
    } command_t;

endpackage

// >>> vr_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for a bundle of pin levels
module vr_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // a bundle needs at least one pin
    if (WIDTH < 1) begin : g_width_check
        $error("pin synchroniser width must be at least one");
    end

    // no reset: pins stand synchronised when reset is released
    // first stage read only by second stage
    always_ff @(posedge clk) begin
        meta_q <= pin_in;
        sync_q <= meta_q;
    end

    assign pin_sync = sync_q;
endmodule // vr_pin_sync
`default_nettype wire

// >>> vr_design_point.sv
`timescale 1ns/10ps
`default_nettype none
// captures pin-set design points once, after reset release
module vr_design_point (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       fast_sel_20,
    input  wire logic [7:0] max_current_pins,
    output logic            loaded,
    output logic      [7:0] max_current_limit,
    output logic      [7:0] fast_slew_setting,
    output logic      [7:0] slow_slew_setting
);
    logic       loaded_q, loaded_d;
    logic [7:0] icc_q, icc_d;
    logic [7:0] fast_q, fast_d;
    logic [7:0] slow_q, slow_d;

    // load on the first edge after power-up reset, then hold
    always_comb begin
        loaded_d = 1'b1;
        icc_d    = icc_q;
        fast_d   = fast_q;
        slow_d   = slow_q;
        if (!loaded_q) begin
            icc_d  = max_current_pins;
            fast_d = fast_sel_20 ? vr_regmap_pkg::SLEW_FAST_20
                                 : vr_regmap_pkg::SLEW_FAST_10;
            slow_d = fast_sel_20 ? vr_regmap_pkg::SLEW_SLOW_FOR_20
                                 : vr_regmap_pkg::SLEW_SLOW_FOR_10;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            loaded_q <= 1'b0;
            icc_q    <= vr_regmap_pkg::RST_MAX_CURRENT;
            fast_q   <= vr_regmap_pkg::SLEW_FAST_10;
            slow_q   <= vr_regmap_pkg::SLEW_SLOW_FOR_10;
        end else begin
            loaded_q <= loaded_d;
            icc_q    <= icc_d;
            fast_q   <= fast_d;
            slow_q   <= slow_d;
        end
    end

    assign loaded            = loaded_q;
    assign max_current_limit = icc_q;
    assign fast_slew_setting = fast_q;
    assign slow_slew_setting = slow_q;
endmodule // vr_design_point
`default_nettype wire

// >>> vr_serial_register_map.sv
`timescale 1ns/10ps
`default_nettype none
module vr_serial_register_map #(
    parameter logic [7:0] MAKER_CODE  = 8'h5a, // arbitrary value
    parameter logic [7:0] PART_CODE   = 8'h3c, // arbitrary value
    parameter logic [7:0] PART_REV    = 8'h01, // arbitrary value
    parameter logic [7:0] DATE_CODE   = 8'h00, // arbitrary value
    parameter logic [7:0] LOT_CODE    = 8'h00  // arbitrary value
) (
    // clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       ARST_N,
    // decoded command from the bus framer
    input  wire logic       CMD_VALID,
    input  wire logic [2:0] CMD_CODE,
    input  wire logic [7:0] CMD_PAYLOAD,
    output logic            RSP_VALID,
    output logic      [7:0] RSP_DATA,
    // regulator telemetry, same clock
    input  wire logic [7:0] FAULT_PRIMARY,
    input  wire logic [7:0] FAULT_SECONDARY,
    input  wire logic [7:0] THERMAL_ZONE,
    input  wire logic [7:0] OUT_CURRENT,
    input  wire logic [7:0] OUT_VOLTAGE,
    input  wire logic [7:0] REG_TEMPERATURE,
    input  wire logic [7:0] OUT_POWER,
    input  wire logic [7:0] IN_CURRENT,
    input  wire logic [7:0] IN_VOLTAGE,
    input  wire logic [7:0] IN_POWER,
    input  wire logic [7:0] SECONDARY_SNAP,
    input  wire logic       STARTUP_DONE,
    // design-point pins, asynchronous
    input  wire logic       FAST_SLEW_SEL_PIN,
    input  wire logic [7:0] MAX_CURRENT_PIN,
    // scratchpad contents to the regulator
    output logic      [7:0] VOUT_CEILING,
    output logic      [7:0] VOLTAGE_TARGET,
    output logic      [7:0] POWER_STATE,
    output logic      [7:0] VOLTAGE_OFFSET,
    output logic      [7:0] MULTI_REG_CONFIG,
    output logic      [7:0] POINTER_COPY,
    output logic            DESIGN_POINTS_LOADED
);

    // ****************************************
    // pin synchronisers and design points
    // ****************************************
    logic [8:0] pins_sync;
    logic [7:0] max_current_limit;
    logic [7:0] fast_slew_setting;
    logic [7:0] slow_slew_setting;
    logic       dp_loaded;

    vr_pin_sync #(
        .WIDTH (9)
    ) u_pin_sync (
        .clk      (CLK_SYS),
        .pin_in   ({FAST_SLEW_SEL_PIN, MAX_CURRENT_PIN}),
        .pin_sync (pins_sync)
    );

    logic dp_arst_n;
    assign dp_arst_n = ARST_N;

    vr_design_point u_design_point (
        .clk               (CLK_SYS),
        .arst_n            (dp_arst_n),
        .fast_sel_20       (pins_sync[8]),
        .max_current_pins  (pins_sync[7:0]),
        .loaded            (dp_loaded),
        .max_current_limit (max_current_limit),
        .fast_slew_setting (fast_slew_setting),
        .slow_slew_setting (slow_slew_setting)
    );

    // ****************************************
    // scratchpad and pointer
    // ****************************************
    logic [7:0] scratch_q [vr_regmap_pkg::SCRATCH_COUNT];
    logic [7:0] scratch_d [vr_regmap_pkg::SCRATCH_COUNT];
    logic [7:0] pointer_q;
    logic [7:0] pointer_d;
    logic       wr_en;
    logic [7:0] wr_idx;
    logic       in_scratch;

    // command decode into a write of one scratchpad entry
    always_comb begin
        wr_en     = 1'b0;
        wr_idx    = vr_regmap_pkg::IDX_VOLTAGE_TARGET;
        pointer_d = pointer_q;
        if (CMD_VALID) begin
            case (CMD_CODE)
                vr_regmap_pkg::CMD_SET_VOLTAGE_FAST,
                vr_regmap_pkg::CMD_SET_VOLTAGE_SLOW,
                vr_regmap_pkg::CMD_SET_VOLTAGE_DECAY: begin
                    wr_en  = 1'b1;
                    wr_idx = vr_regmap_pkg::IDX_VOLTAGE_TARGET;
                end
                vr_regmap_pkg::CMD_SET_POWER_STATE: begin
                    wr_en  = 1'b1;
                    wr_idx = vr_regmap_pkg::IDX_POWER_STATE;
                end
                vr_regmap_pkg::CMD_REGISTER_POINTER: begin
                    pointer_d = CMD_PAYLOAD;
                end
                vr_regmap_pkg::CMD_REGISTER_WRITE: begin
                    wr_en  = 1'b1;
                    wr_idx = pointer_q;
                end
                default: begin
                    wr_en = 1'b0;
                end
            endcase
        end
    end

    // identity, telemetry and design points never match: writes dropped
    assign in_scratch = (wr_idx >= vr_regmap_pkg::IDX_SCRATCH_FIRST) &&
                        (wr_idx <= vr_regmap_pkg::IDX_SCRATCH_LAST);

    // per-entry next value
    genvar gi;
    generate
        for (gi = 0; gi < vr_regmap_pkg::SCRATCH_COUNT; gi++) begin : g_scr
            localparam logic [7:0] MY_IDX =
                8'(vr_regmap_pkg::IDX_SCRATCH_FIRST + gi);
            always_comb begin
                scratch_d[gi] = scratch_q[gi];
                if (wr_en && in_scratch && (wr_idx == MY_IDX)) begin
                    scratch_d[gi] = CMD_PAYLOAD;
                end
            end

            // reset models loss of power: defaults return
            always_ff @(posedge CLK_SYS or negedge ARST_N) begin
                if (!ARST_N) begin
                    if (gi == 0) begin
                        scratch_q[gi] <= vr_regmap_pkg::RST_VOUT_CEILING;
                    end else begin
                        scratch_q[gi] <= vr_regmap_pkg::RST_SCRATCH;
                    end
                end else begin
                    scratch_q[gi] <= scratch_d[gi];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pointer_q <= vr_regmap_pkg::RST_SCRATCH;
        end else begin
            pointer_q <= pointer_d;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    logic [7:0] rd_val;
    logic [7:0] rsp_data_q, rsp_data_d;
    logic       rsp_valid_q, rsp_valid_d;
    logic [7:0] rd_idx;

    assign rd_idx = CMD_PAYLOAD;

    // entry lookup by index
    always_comb begin
        case (rd_idx)
            vr_regmap_pkg::IDX_MAKER_CODE:       rd_val = MAKER_CODE;
            vr_regmap_pkg::IDX_PART_CODE:        rd_val = PART_CODE;
            vr_regmap_pkg::IDX_PART_REVISION:    rd_val = PART_REV;
            vr_regmap_pkg::IDX_MANUFACTURE_DATE: rd_val = DATE_CODE;
            vr_regmap_pkg::IDX_MANUFACTURE_LOT:  rd_val = LOT_CODE;
            vr_regmap_pkg::IDX_PROTOCOL_VERSION:
                rd_val = vr_regmap_pkg::RST_PROTOCOL_VERSION;
            vr_regmap_pkg::IDX_FEATURE_FLAGS:
                rd_val = vr_regmap_pkg::RST_FEATURE_FLAGS;
            vr_regmap_pkg::IDX_FAULT_PRIMARY:    rd_val = FAULT_PRIMARY;
            vr_regmap_pkg::IDX_FAULT_SECONDARY:  rd_val = FAULT_SECONDARY;
            vr_regmap_pkg::IDX_THERMAL_ZONE:     rd_val = THERMAL_ZONE;
            vr_regmap_pkg::IDX_OUT_CURRENT:
                rd_val = STARTUP_DONE ? OUT_CURRENT
                                      : vr_regmap_pkg::RST_STATUS;
            vr_regmap_pkg::IDX_OUT_VOLTAGE:      rd_val = OUT_VOLTAGE;
            vr_regmap_pkg::IDX_REG_TEMPERATURE:  rd_val = REG_TEMPERATURE;
            vr_regmap_pkg::IDX_OUT_POWER:        rd_val = OUT_POWER;
            vr_regmap_pkg::IDX_IN_CURRENT:       rd_val = IN_CURRENT;
            vr_regmap_pkg::IDX_IN_VOLTAGE:       rd_val = IN_VOLTAGE;
            vr_regmap_pkg::IDX_IN_POWER:         rd_val = IN_POWER;
            vr_regmap_pkg::IDX_SECONDARY_SNAP:   rd_val = SECONDARY_SNAP;
            vr_regmap_pkg::IDX_MAX_CURRENT:      rd_val = max_current_limit;
            vr_regmap_pkg::IDX_MAX_TEMPERATURE:
                rd_val = vr_regmap_pkg::RST_MAX_TEMPERATURE;
            vr_regmap_pkg::IDX_FAST_SLEW:        rd_val = fast_slew_setting;
            vr_regmap_pkg::IDX_SLOW_SLEW:        rd_val = slow_slew_setting;
            vr_regmap_pkg::IDX_STARTUP_VOLTAGE:
                rd_val = vr_regmap_pkg::RST_STARTUP_VOLTAGE;
            vr_regmap_pkg::IDX_VOUT_CEILING:     rd_val = scratch_q[0];
            vr_regmap_pkg::IDX_VOLTAGE_TARGET:   rd_val = scratch_q[1];
            vr_regmap_pkg::IDX_POWER_STATE:      rd_val = scratch_q[2];
            vr_regmap_pkg::IDX_VOLTAGE_OFFSET:   rd_val = scratch_q[3];
            vr_regmap_pkg::IDX_MULTI_REG_CONFIG: rd_val = scratch_q[4];
            vr_regmap_pkg::IDX_POINTER_COPY:     rd_val = scratch_q[5];
            default:                             rd_val = vr_regmap_pkg::READ_UNMAPPED;
        endcase
    end

    // read answer registered one cycle after the command
    always_comb begin
        rsp_valid_d = CMD_VALID &&
                      (CMD_CODE == vr_regmap_pkg::CMD_REGISTER_READ);
        rsp_data_d  = rsp_valid_d ? rd_val : rsp_data_q;
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rsp_valid_q <= 1'b0;
            rsp_data_q  <= vr_regmap_pkg::READ_UNMAPPED;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q  <= rsp_data_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign RSP_VALID            = rsp_valid_q;
    assign RSP_DATA             = rsp_data_q;
    assign VOUT_CEILING         = scratch_q[0];
    assign VOLTAGE_TARGET       = scratch_q[1];
    assign POWER_STATE          = scratch_q[2];
    assign VOLTAGE_OFFSET       = scratch_q[3];
    assign MULTI_REG_CONFIG     = scratch_q[4];
    assign POINTER_COPY         = scratch_q[5];
    assign DESIGN_POINTS_LOADED = dp_loaded;

endmodule // vr_serial_register_map
`default_nettype wire

// >>> vr_cmd_master.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// processor-side command source
// ****************************************
module vr_cmd_master (
    // clock
    input  wire logic       clk,
    // decoded command toward the bank
    output logic            cmd_valid,
    output logic      [2:0] cmd_code,
    output logic      [7:0] cmd_payload
);
    // quiet bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 3'h0;
        cmd_payload = 8'h00;
    end
    // one command held over one taking edge
    task automatic send(input logic [2:0] c, input logic [7:0] p);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_payload <= p;
        @(posedge clk);
    endtask
    // released payload stops showing the last value
    task automatic idle();
        cmd_valid <= 1'b0;
        cmd_payload <= ~cmd_payload;
        @(posedge clk);
    endtask
endmodule // vr_cmd_master
`default_nettype wire

// >>> vr_regmap_chk_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// port checker for the register bank
// ****************************************
module vr_regmap_chk (
    // clock and reset
    input  wire logic       CLK_SYS,
    input  wire logic       ARST_N,
    // command side
    input  wire logic       CMD_VALID,
    input  wire logic [2:0] CMD_CODE,
    input  wire logic [7:0] CMD_PAYLOAD,
    input  wire logic       RSP_VALID,
    input  wire logic [7:0] RSP_DATA,
    // telemetry and scratch
    input  wire logic [7:0] FAULT_PRIMARY,
    input  wire logic [7:0] OUT_CURRENT,
    input  wire logic       STARTUP_DONE,
    input  wire logic [7:0] VOUT_CEILING,
    input  wire logic [7:0] VOLTAGE_TARGET,
    input  wire logic [7:0] POWER_STATE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // read decode
    sequence s_rd(logic [7:0] i);
        CMD_VALID && CMD_CODE == 3'h7 && CMD_PAYLOAD == i;
    endsequence
    property p_rsp;
        CMD_VALID && CMD_CODE == 3'h7 |=> RSP_VALID;
    endproperty
    a_rsp: assert property (p_rsp)
        else $error("read answer missing");
    property p_rsp_src;
        RSP_VALID |-> $past(CMD_VALID && CMD_CODE == 3'h7);
    endproperty
    a_rsp_src: assert property (p_rsp_src)
        else $error("answer without a read");
    property p_rsp_hold;
        !(CMD_VALID && CMD_CODE == 3'h7) |=> $stable(RSP_DATA);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold)
        else $error("read data moved without a read");
    property p_vid;
        CMD_VALID && CMD_CODE inside {3'h1, 3'h2, 3'h3}
            |=> VOLTAGE_TARGET == $past(CMD_PAYLOAD);
    endproperty
    a_vid: assert property (p_vid)
        else $error("voltage target not taken");
    property p_ps;
        CMD_VALID && CMD_CODE == 3'h4 |=> POWER_STATE == $past(CMD_PAYLOAD);
    endproperty
    a_ps: assert property (p_ps)
        else $error("power state not taken");
    property p_ident;
        s_rd(8'h05) |=> RSP_DATA == 8'h02;
    endproperty
    a_ident: assert property (p_ident)
        else $error("protocol version wrong");
    property p_telem;
        s_rd(8'h10) |=> RSP_DATA == $past(FAULT_PRIMARY);
    endproperty
    a_telem: assert property (p_telem)
        else $error("fault status not live");
    property p_iout;
        CMD_VALID && CMD_CODE == 3'h7 && CMD_PAYLOAD == 8'h15 && STARTUP_DONE
            |=> RSP_DATA == $past(OUT_CURRENT);
    endproperty
    a_iout: assert property (p_iout)
        else $error("output current not measured value");
    property p_slew;
        s_rd(8'h24) |=> RSP_DATA inside {8'h0a, 8'h14};
    endproperty
    a_slew: assert property (p_slew)
        else $error("fast slew out of set");
    property p_hold;
        !CMD_VALID |=> $stable(VOUT_CEILING);
    endproperty
    a_hold: assert property (p_hold)
        else $error("ceiling moved without a command");
    property p_rst;
        $rose(ARST_N) |-> VOUT_CEILING == 8'hff && VOLTAGE_TARGET == 8'h00
            && POWER_STATE == 8'h00 && !RSP_VALID;
    endproperty
    a_rst: assert property (p_rst)
        else $error("scratch defaults not restored");
    // main scenarios
    c_read: cover property (RSP_VALID);
    c_write: cover property (CMD_VALID && CMD_CODE == 3'h6);
    c_ps: cover property (CMD_VALID && CMD_CODE == 3'h4);
endmodule // vr_regmap_chk
bind vr_serial_register_map vr_regmap_chk i_chk (.CLK_SYS, .ARST_N,
    .CMD_VALID, .CMD_CODE, .CMD_PAYLOAD, .RSP_VALID, .RSP_DATA,
    .FAULT_PRIMARY, .OUT_CURRENT, .STARTUP_DONE, .VOUT_CEILING,
    .VOLTAGE_TARGET, .POWER_STATE);
`default_nettype wire

// >>> vr_serial_register_map_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// self-checking bench
// ****************************************
module vr_serial_register_map_tb_top;
    localparam logic [7:0] MK = 8'h6b; // arbitrary value
    localparam logic [7:0] PC = 8'h4e; // arbitrary value
    localparam logic [7:0] PR = 8'h03; // arbitrary value
    localparam logic [7:0] DC = 8'h19; // arbitrary value
    localparam logic [7:0] LC = 8'h2d; // arbitrary value
    logic       clk_sys = 1'b0;
    logic       arst_n  = 1'b0;
    logic       cmd_valid;
    logic [2:0] cmd_code;
    logic [7:0] cmd_payload;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic [7:0] tel [0:10];
    logic       startup_done = 1'b0;
    logic [7:0] imax_pin;
    logic       fast_pin;
    logic [7:0] scr [0:5];
    logic [7:0] mdl [0:5];
    logic       loaded;
    logic [7:0] ptr;
    logic [7:0] d;
    logic [7:0] f;
    int         fails = 0;
    int         n_tests = 0;
    // clock
    always #4 clk_sys = ~clk_sys;
    vr_cmd_master i_m (.clk(clk_sys), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_payload(cmd_payload));
    vr_serial_register_map #(.MAKER_CODE(MK), .PART_CODE(PC),
        .PART_REV(PR), .DATE_CODE(DC), .LOT_CODE(LC)) i_dut (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .CMD_VALID(cmd_valid),
        .CMD_CODE(cmd_code), .CMD_PAYLOAD(cmd_payload),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .FAULT_PRIMARY(tel[0]), .FAULT_SECONDARY(tel[1]),
        .THERMAL_ZONE(tel[2]), .OUT_CURRENT(tel[3]),
        .OUT_VOLTAGE(tel[4]), .REG_TEMPERATURE(tel[5]),
        .OUT_POWER(tel[6]), .IN_CURRENT(tel[7]), .IN_VOLTAGE(tel[8]),
        .IN_POWER(tel[9]), .SECONDARY_SNAP(tel[10]),
        .STARTUP_DONE(startup_done), .FAST_SLEW_SEL_PIN(fast_pin),
        .MAX_CURRENT_PIN(imax_pin), .VOUT_CEILING(scr[0]),
        .VOLTAGE_TARGET(scr[1]), .POWER_STATE(scr[2]),
        .VOLTAGE_OFFSET(scr[3]), .MULTI_REG_CONFIG(scr[4]),
        .POINTER_COPY(scr[5]), .DESIGN_POINTS_LOADED(loaded));
    // reference contents of one entry
    function automatic logic [7:0] exp_rd(input logic [7:0] i);
        case (i)
            8'h00: return MK;
            8'h01: return PC;
            8'h02: return PR;
            8'h03: return DC;
            8'h04: return LC;
            8'h05: return 8'h02;
            8'h06: return 8'hd7;
            8'h15: return startup_done ? tel[3] : 8'h00;
            8'h21: return imax_pin;
            8'h22: return 8'h96;
            8'h26: return 8'h7e;
            default: ;
        endcase
        if (i inside {[8'h10:8'h12]}) return tel[i - 8'h10];
        if (i inside {[8'h16:8'h1c]}) return tel[i - 8'h12];
        if (i inside {[8'h30:8'h35]}) return mdl[i - 8'h30];
        return 8'h00;
    endfunction
    // comparison and verdict
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_tests++;
        if (seen !== want) begin
            fails++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // bus operations
    // answer pulse looked at in the cycle it stands
    task automatic rd(input logic [7:0] i, output logic [7:0] v);
        i_m.send(3'h7, i);
        #1;
        check({7'h00, rsp_valid}, 8'h01);
        v = rsp_data;
        i_m.idle();
    endtask
    task automatic chk_scr();
        for (int k = 0; k < 6; k++) check(scr[k], mdl[k]);
    endtask
    task automatic pt(input logic [7:0] i);
        i_m.send(3'h5, i);
        ptr = i;
    endtask
    task automatic wd(input logic [7:0] v);
        i_m.send(3'h6, v);
        i_m.idle();
        #1;
        if (ptr inside {[8'h30:8'h35]}) mdl[ptr - 8'h30] = v;
        chk_scr();
    endtask
    // design points against the pins applied before reset release
    task automatic chk_dp();
        rd(8'h21, d);
        check(d, imax_pin);
        rd(8'h24, f);
        check(f, fast_pin ? 8'h14 : 8'h0a);
        rd(8'h25, d);
        check(d, fast_pin ? 8'h05 : 8'h02);
    endtask
    task automatic rst_mdl();
        mdl[0] = 8'hff;
        for (int k = 1; k < 6; k++) mdl[k] = 8'h00;
    endtask
    // watchdog
    initial begin
        #100000;
        fails++;
        complete_run();
    end
    // main sequence
    initial begin
        foreach (tel[k]) tel[k] = 8'h00;
        rst_mdl();
        void'($urandom(32'h7fb6e9d4));
        fast_pin <= 1'($urandom());
        imax_pin <= 8'($urandom());
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        foreach (tel[k]) tel[k] <= 8'($urandom());
        @(posedge clk_sys);
        #1;
        check({7'h00, loaded}, 8'h01);
        chk_scr();
        for (int i = 0; i < 64; i++) begin
            if (i == 8'h24 || i == 8'h25) continue;
            rd(8'(i), d);
            check(d, exp_rd(8'(i)));
        end
        chk_dp();
        startup_done <= 1'b1;
        rd(8'h15, d);
        check(d, tel[3]);
        for (int k = 0; k < 6; k++) begin
            pt(8'h30 + 8'(k));
            wd(8'($urandom()));
            wd(8'($urandom()));
        end
        foreach (tel[k]) tel[k] <= 8'($urandom());
        for (int k = 0; k < 4; k++) begin
            pt(8'h10 + 8'(k * 5));
            wd(8'($urandom()));
            rd(ptr, d);
            check(d, exp_rd(ptr));
        end
        pt(8'h05);
        wd(8'h99);
        rd(8'h05, d);
        check(d, 8'h02);
        pt(8'h21);
        wd(8'h77);
        rd(8'h21, d);
        check(d, imax_pin);
        pt(8'h40);
        wd(8'h5a);
        // code 0 is unknown and must leave the scratchpad alone
        for (int c = 0; c < 5; c++) begin
            d = 8'($urandom());
            i_m.send(3'(c), d);
            i_m.idle();
            #1;
            if (c > 0) mdl[(c == 4) ? 2 : 1] = d;
            chk_scr();
        end
        for (int i = 8'h30; i < 8'h36; i++) begin
            rd(8'(i), d);
            check(d, exp_rd(8'(i)));
        end
        // other pin settings across a power cycle
        fast_pin <= ~fast_pin;
        imax_pin <= 8'($urandom());
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        rst_mdl();
        @(posedge clk_sys);
        #1;
        chk_scr();
        check({7'h00, loaded}, 8'h01);
        chk_dp();
        complete_run();
    end
endmodule // vr_serial_register_map_tb_top
`default_nettype wire
